/* verilog/aits_top.v */
// analog input trip supervisor: low and high trip levels with delays
// and start grace windows, registers over axi4-lite.
// assumes motor_start is a one-cycle pulse and all inputs are
// synchronous to aclk.
//
// Summary of operation
// - low side must heal within grace after start
// - zero grace checks value at start instant
// - low grace OFF trips whenever value unhealthy
// - low trip after continuous low for delay
// - high level 1..20000 or OFF, flags excess
// - high side must heal within grace after start
// - high grace OFF trips whenever value unhealthy
// - value scaled linearly, 20 mA is maximum
// - low level 1..20000 or OFF, flags drop
//
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`include "aits_map.vh"

module aits_top #(
  parameter TICK_CYCLES = `AITS_TICK_CYCLES
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [`AITS_VAL_W-1:0] loop_ua,
  input wire motor_start,
  input wire motor_running,
  output wire low_trip,
  output wire high_trip
);

  // ---------------------------------------------------------------------
  // configuration and status storage, index 0 low side, 1 high side
  // ---------------------------------------------------------------------
  reg [`AITS_VAL_W-1:0] level_r [0:1];
  reg [`AITS_SEC_W-1:0] delay_r [0:1];
  reg [`AITS_SEC_W-1:0] grace_r [0:1];
  reg [`AITS_VAL_W-1:0] scale_floor_value_r;
  reg [`AITS_VAL_W-1:0] scale_max_r;
  reg [1:0] trip_r;
  wire [1:0] trip_set;
  wire [1:0] cond;
  wire [1:0] grace_act;
  wire [`AITS_VAL_W-1:0] scaled;
  integer k;

  // ---------------------------------------------------------------------
  // one-second time base
  // ---------------------------------------------------------------------
  reg [31:0] div_r;
  reg tick_r;

  // a single enable pulse keeps every timer in the one clock domain
  always @(posedge aclk) begin
    if (!aresetn) begin
      div_r <= 32'h00000000;
      tick_r <= 1'b0;
    end else if (div_r == TICK_CYCLES - 1) begin
      div_r <= 32'h00000000;
      tick_r <= 1'b1;
    end else begin
      div_r <= div_r + 32'h00000001;
      tick_r <= 1'b0;
    end
  end

  aits_scaler u_scaler (
    .aclk(aclk),
    .aresetn(aresetn),
    .loop_ua(loop_ua),
    .scale_floor_value(scale_floor_value_r),
    .scale_max_value(scale_max_r),
    .scaled_r(scaled)
  );

  // ---------------------------------------------------------------------
  // per-side supervision
  // ---------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_side
      reg [`AITS_SEC_W-1:0] dly_cnt_r;
      reg [`AITS_SEC_W-1:0] grc_cnt_r;
      reg grc_act_r;
      wire off;
      wire bad;
      wire dly_done;
      wire grc_off;
      wire grc_zero;
      wire start_fail;
      wire grc_fail;
      wire run_trip;

      assign off = (level_r[i] == `AITS_LEVEL_OFF);
      // low side unhealthy below level, high side above it
      assign bad = ~off & ((i == 0) ? (scaled < level_r[i])
                                    : (scaled > level_r[i]));
      assign dly_done = bad & (dly_cnt_r >= delay_r[i]);
      assign grc_off = (grace_r[i] == `AITS_GRACE_OFF);
      assign grc_zero = (grace_r[i] == 10'h000);
      assign start_fail = motor_start & grc_zero & bad;
      assign grc_fail = grc_act_r & tick_r & bad &
                        (grc_cnt_r + 10'h001 >= grace_r[i]);
      // OFF grace trips whether or not the motor runs
      assign run_trip = dly_done &
                        (grc_off | (motor_running & ~grc_act_r));
      assign trip_set[i] = start_fail | grc_fail | run_trip;
      assign cond[i] = bad;
      assign grace_act[i] = grc_act_r;

      // delay timer counts whole seconds of continuous excursion
      always @(posedge aclk) begin
        if (!aresetn || off || !bad)
          dly_cnt_r <= 10'h000;
        else if (tick_r && dly_cnt_r != 10'h3FF)
          dly_cnt_r <= dly_cnt_r + 10'h001;
      end

      // grace window opens at a start and closes on heal or expiry
      always @(posedge aclk) begin
        if (!aresetn || off) begin
          grc_act_r <= 1'b0;
          grc_cnt_r <= 10'h000;
        end else if (motor_start && !grc_off && !grc_zero) begin
          grc_act_r <= 1'b1;
          grc_cnt_r <= 10'h000;
        end else if (grc_act_r && (!bad || grc_fail)) begin
          grc_act_r <= 1'b0;
        end else if (grc_act_r && tick_r) begin
          grc_cnt_r <= grc_cnt_r + 10'h001;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------------
  // axi4-lite write channel
  // ---------------------------------------------------------------------
  reg aw_got_r;
  reg w_got_r;
  reg [7:0] awaddr_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  wire wr_go;
  wire wr_ok;
  wire [1:0] clr;

  assign s_axi_awready = ~aw_got_r & ~s_axi_bvalid;
  assign s_axi_wready = ~w_got_r & ~s_axi_bvalid;
  assign wr_go = aw_got_r & w_got_r & ~s_axi_bvalid;
  assign wr_ok = (awaddr_r[1:0] == 2'h0) &&
                 (awaddr_r <= `AITS_OFS_VALUE) &&
                 (awaddr_r != `AITS_OFS_VALUE);
  assign clr = (wr_go && awaddr_r == `AITS_OFS_STATUS && wstrb_r[0]) ?
               wdata_r[1:0] : 2'h0;

  // byte-lane mask; lanes above bit 15 never reach any field
  wire [15:0] wm = {{8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  wire [15:0] wv = wdata_r[15:0] & wm;

  // address and data may arrive in either order; answer two cycles after the later one
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // configuration writes; unwritten byte lanes keep their old bits
  always @(posedge aclk) begin
    if (!aresetn) begin
      for (k = 0; k < 2; k = k + 1) begin
        level_r[k] <= `AITS_RST_LEVEL;
        delay_r[k] <= `AITS_RST_DELAY;
        grace_r[k] <= `AITS_RST_GRACE;
      end
      scale_floor_value_r <= `AITS_RST_FLOOR;
      scale_max_r <= `AITS_RST_MAX;
    end else if (wr_go) begin
      case (awaddr_r)
        `AITS_OFS_LOW_LEVEL: level_r[0] <= level_r[0] & ~wm[14:0] | wv[14:0];
        `AITS_OFS_HIGH_LEVEL: level_r[1] <= level_r[1] & ~wm[14:0] | wv[14:0];
        `AITS_OFS_LOW_DELAY: delay_r[0] <= delay_r[0] & ~wm[9:0] | wv[9:0];
        `AITS_OFS_HIGH_DELAY: delay_r[1] <= delay_r[1] & ~wm[9:0] | wv[9:0];
        `AITS_OFS_LOW_GRACE: grace_r[0] <= grace_r[0] & ~wm[9:0] | wv[9:0];
        `AITS_OFS_HIGH_GRACE: grace_r[1] <= grace_r[1] & ~wm[9:0] | wv[9:0];
        `AITS_OFS_SCALE_FLOOR: scale_floor_value_r <=
          scale_floor_value_r & ~wm[14:0] | wv[14:0];
        `AITS_OFS_SCALE_MAX: scale_max_r <= scale_max_r & ~wm[14:0] | wv[14:0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // sticky trips; a new trip wins over a clear in the same cycle
  // ---------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn)
      trip_r <= 2'h0;
    else
      trip_r <= (trip_r & ~clr) | trip_set;
  end

  assign low_trip = trip_r[`AITS_ST_TRIP_LO];
  assign high_trip = trip_r[`AITS_ST_TRIP_HI];

  // ---------------------------------------------------------------------
  // axi4-lite read channel
  // ---------------------------------------------------------------------
  reg [31:0] rd_nxt;
  reg rd_ok;

  assign s_axi_arready = ~s_axi_rvalid;

  always @* begin
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `AITS_OFS_LOW_LEVEL: rd_nxt = {17'h00000, level_r[0]};
      `AITS_OFS_HIGH_LEVEL: rd_nxt = {17'h00000, level_r[1]};
      `AITS_OFS_LOW_DELAY: rd_nxt = {22'h000000, delay_r[0]};
      `AITS_OFS_HIGH_DELAY: rd_nxt = {22'h000000, delay_r[1]};
      `AITS_OFS_LOW_GRACE: rd_nxt = {22'h000000, grace_r[0]};
      `AITS_OFS_HIGH_GRACE: rd_nxt = {22'h000000, grace_r[1]};
      `AITS_OFS_SCALE_FLOOR: rd_nxt = {17'h00000, scale_floor_value_r};
      `AITS_OFS_SCALE_MAX: rd_nxt = {17'h00000, scale_max_r};
      `AITS_OFS_STATUS: rd_nxt = {26'h0000000, grace_act, cond, trip_r};
      `AITS_OFS_VALUE: rd_nxt = {17'h00000, scaled};
      default: begin
        rd_nxt = 32'h00000000;
        rd_ok = 1'b0;
      end
    endcase
  end

  // the read answer follows the address by one cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_nxt;
      s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

/* inc/aits_map.vh */
// register map, field layout, reset values and timing counts of the
// analog input trip supervisor.
// assumes a 32-bit axi4-lite bus with one aligned word per register.
`ifndef AITS_MAP_VH
`define AITS_MAP_VH

// ---------------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------------
`define AITS_OFS_LOW_LEVEL 8'h00
`define AITS_OFS_HIGH_LEVEL 8'h04
`define AITS_OFS_LOW_DELAY 8'h08
`define AITS_OFS_HIGH_DELAY 8'h0C
`define AITS_OFS_LOW_GRACE 8'h10
`define AITS_OFS_HIGH_GRACE 8'h14
`define AITS_OFS_SCALE_FLOOR 8'h18
`define AITS_OFS_SCALE_MAX 8'h1C
`define AITS_OFS_STATUS 8'h20
`define AITS_OFS_VALUE 8'h24

// ---------------------------------------------------------------------
// field widths and status bit positions
// ---------------------------------------------------------------------
`define AITS_VAL_W 15
`define AITS_SEC_W 10
`define AITS_ST_TRIP_LO 0
`define AITS_ST_TRIP_HI 1
`define AITS_ST_COND_LO 2
`define AITS_ST_COND_HI 3
`define AITS_ST_GRACE_LO 4
`define AITS_ST_GRACE_HI 5

// ---------------------------------------------------------------------
// encodings and reset values
// ---------------------------------------------------------------------
`define AITS_LEVEL_OFF 15'h0000
`define AITS_GRACE_OFF 10'h3FF
`define AITS_RST_LEVEL 15'h0000
`define AITS_RST_DELAY 10'h005
`define AITS_RST_GRACE 10'h005
`define AITS_RST_FLOOR 15'h0000
`define AITS_RST_MAX 15'h03E8

// ---------------------------------------------------------------------
// loop current span in microamps and time base
// ---------------------------------------------------------------------
`define AITS_LOOP_MIN_UA 15'h0FA0
`define AITS_LOOP_MAX_UA 15'h4E20
`define AITS_LOOP_SPAN_UA 29'h00003E80
`define AITS_TICK_TIME_S 1
`define AITS_CLK_HZ 50000000
`define AITS_TICK_CYCLES (`AITS_TICK_TIME_S * `AITS_CLK_HZ)

`endif

/* verilog/aits_scaler.v */
// linear scaler from loop current in microamps to an engineering value.
// assumes loop_ua is synchronous to aclk and updates at any rate.
`timescale 1ns/10ps
`include "aits_map.vh"

module aits_scaler (
  input wire aclk,
  input wire aresetn,
  input wire [`AITS_VAL_W-1:0] loop_ua,
  input wire [`AITS_VAL_W-1:0] scale_floor_value,
  input wire [`AITS_VAL_W-1:0] scale_max_value,
  output reg [`AITS_VAL_W-1:0] scaled_r
);

  // ---------------------------------------------------------------------
  // clamp, offset and scale
  // ---------------------------------------------------------------------
  reg [`AITS_VAL_W-1:0] ua_c;
  reg [`AITS_VAL_W-1:0] span;
  reg [28:0] prod;
  reg [28:0] quot;
  reg [`AITS_VAL_W-1:0] scaled_nxt;

  // below 4 ma reads as floor, above 20 ma reads as maximum scale
  always @* begin
    if (loop_ua < `AITS_LOOP_MIN_UA)
      ua_c = 15'h0000;
    else if (loop_ua > `AITS_LOOP_MAX_UA)
      ua_c = `AITS_LOOP_MAX_UA - `AITS_LOOP_MIN_UA;
    else
      ua_c = loop_ua - `AITS_LOOP_MIN_UA;
    // an inverted scale is treated as a flat one rather than wrapping
    if (scale_max_value > scale_floor_value)
      span = scale_max_value - scale_floor_value;
    else
      span = 15'h0000;
    prod = {14'h0000, ua_c} * {14'h0000, span};
    quot = prod / `AITS_LOOP_SPAN_UA;
    scaled_nxt = scale_floor_value + quot[`AITS_VAL_W-1:0];
  end

  // register the value; one cycle of latency hides the divider path
  always @(posedge aclk) begin
    if (!aresetn)
      scaled_r <= 15'h0000;
    else
      scaled_r <= scaled_nxt;
  end

endmodule

/* verif/aits_asserts.sv */
// checker for the trip supervisor ports: bus handshakes and trip flags.
// assumes it is bound to aits_top and sees only that module's ports.
`timescale 1ns/10ps
module aits_asserts (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire low_trip,
  input wire high_trip
);
  // ----------------------------------------------------------------
  // properties, all in the aclk domain
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  a_ar_gate: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("arready not inverse of rvalid");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read not answered");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
    else $error("write not answered");
  a_aw_blocked: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready) else $error("ready during bvalid");
  // trips only fall with a status write, which shows as bvalid
  a_low_sticky: assert property (low_trip && !s_axi_bvalid
    |=> low_trip || s_axi_bvalid) else $error("low trip fell");
  a_high_sticky: assert property (high_trip && !s_axi_bvalid
    |=> high_trip || s_axi_bvalid) else $error("high trip fell");
  a_reset_clears: assert property (disable iff (1'b0) !aresetn
    |=> !low_trip && !high_trip) else $error("trip through reset");
  c_low: cover property ($rose(low_trip));
  c_high: cover property ($rose(high_trip));
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule

bind aits_top aits_asserts aits_asserts_i (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .low_trip, .high_trip);

/* verif/aits_field.sv */
// model of the transducer loop and the motor start contacts.
// assumes the bench calls its tasks from the aclk domain.
`timescale 1ns/10ps
module aits_field (
  input wire aclk,
  output logic [14:0] loop_ua,
  output logic motor_start,
  output logic motor_running
);
  // a live loop is always driven, so no released state exists
  initial begin
    loop_ua = 15'h0FA0;
    motor_start = 1'b0;
    motor_running = 1'b0;
  end
  task automatic set_ua(input logic [14:0] ua);
    @(posedge aclk);
    loop_ua <= ua;
  endtask
  // start is a one-cycle pulse, running stays up until stop
  task automatic start();
    @(posedge aclk);
    motor_start <= 1'b1;
    motor_running <= 1'b1;
    @(posedge aclk);
    motor_start <= 1'b0;
  endtask
  task automatic stop();
    @(posedge aclk);
    motor_running <= 1'b0;
  endtask
endmodule

/* verif/test_analog_input_trip_supervisor.sv */
// self-checking bench for the analog input trip supervisor.
// assumes one bus master here and a tick shortened to 10 cycles.
`timescale 1ns/10ps
`include "aits_map.vh"
module test_analog_input_trip_supervisor;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, rv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] rr;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, low_trip, high_trip, motor_start, motor_running;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [14:0] loop_ua;
  int err_total, checked;
  aits_top #(.TICK_CYCLES(10)) aits_top_i (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .loop_ua, .motor_start,
    .motor_running, .low_trip, .high_trip);
  aits_field aits_field_i (.aclk, .loop_ua, .motor_start, .motor_running);
  // ----------------------------------------------------------------
  // clock, compare and verdict
  // ----------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  task automatic chk(input string nm, input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic summarize();
    if (err_total == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // ----------------------------------------------------------------
  // bus tasks: hold each channel until its own ready
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (n < 40) begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        s_axi_bready <= 1'b0;
        chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
        n = 99;
      end
    end
    if (n != 99) chk("bvalid", 32'h0, 32'h1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (n < 40) begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        s_axi_rready <= 1'b0;
        rv = s_axi_rdata;
        rr = s_axi_rresp;
        n = 99;
      end
    end
    if (n != 99) chk("rvalid", 32'h0, 32'h1);
    chk("rdata", rv, e);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rd(`AITS_OFS_LOW_LEVEL, 32'h0);
    rd(`AITS_OFS_HIGH_LEVEL, 32'h0);
    rd(`AITS_OFS_LOW_DELAY, 32'h5);
    rd(`AITS_OFS_HIGH_GRACE, 32'h5);
    rd(`AITS_OFS_SCALE_MAX, 32'h3E8);
    wr(`AITS_OFS_LOW_LEVEL, 32'h4E20, 2'h0);
    rd(`AITS_OFS_LOW_LEVEL, 32'h4E20);
    // only byte lane 0 enabled: the upper byte of the level must survive
    s_axi_wstrb <= 4'h1;
    wr(`AITS_OFS_LOW_LEVEL, 32'h0000FF12, 2'h0);
    s_axi_wstrb <= 4'hF;
    rd(`AITS_OFS_LOW_LEVEL, 32'h4E12);
    rd(8'h40, 32'h0);
    chk("rresp", {30'h0, rr}, 32'h2);
    wr(8'h40, 32'h1, 2'h2);
    wr(`AITS_OFS_VALUE, 32'h1, 2'h2);
  endtask
  // floor plus share of span: 12 mA is half way
  task automatic t_scale();
    aits_field_i.set_ua(15'h2EE0);
    wt(5);
    rd(`AITS_OFS_VALUE, 32'h1F4);
    wr(`AITS_OFS_SCALE_FLOOR, 32'h64, 2'h0);
    wr(`AITS_OFS_SCALE_MAX, 32'h44C, 2'h0);
    wt(4);
    rd(`AITS_OFS_VALUE, 32'h258);
    wr(`AITS_OFS_SCALE_FLOOR, 32'h0, 2'h0);
    wr(`AITS_OFS_SCALE_MAX, 32'h3E8, 2'h0);
  endtask
  // motor stopped throughout, so only the off-grace path can trip
  // the level goes first so the old delay count is cleared before OFF grace
  task automatic t_low_delay();
    wr(`AITS_OFS_LOW_LEVEL, 32'h190, 2'h0);
    wr(`AITS_OFS_LOW_GRACE, 32'h3FF, 2'h0);
    wr(`AITS_OFS_LOW_DELAY, 32'h3, 2'h0);
    aits_field_i.set_ua(15'h0FA0);
    wt(18);
    aits_field_i.set_ua(15'h4E20);
    wt(5);
    chk("low_trip", low_trip, 32'h0);
    aits_field_i.set_ua(15'h0FA0);
    wt(18);
    chk("low_trip", low_trip, 32'h0);
    wt(20);
    chk("low_trip", low_trip, 32'h1);
    aits_field_i.set_ua(15'h4E20);
    wr(`AITS_OFS_STATUS, 32'h1, 2'h0);
    chk("low_trip", low_trip, 32'h0);
  endtask
  task automatic t_low_start();
    wr(`AITS_OFS_LOW_DELAY, 32'h258, 2'h0);
    wr(`AITS_OFS_LOW_GRACE, 32'h0, 2'h0);
    aits_field_i.start();
    wt(3);
    chk("low_trip", low_trip, 32'h0);
    aits_field_i.stop();
    aits_field_i.set_ua(15'h0FA0);
    wt(4);
    aits_field_i.start();
    wt(2);
    chk("low_trip", low_trip, 32'h1);
    aits_field_i.stop();
    wr(`AITS_OFS_LOW_GRACE, 32'h2, 2'h0);
    wr(`AITS_OFS_STATUS, 32'h1, 2'h0);
    aits_field_i.start();
    wt(8);
    chk("low_trip", low_trip, 32'h0);
    wt(30);
    chk("low_trip", low_trip, 32'h1);
    aits_field_i.stop();
    wr(`AITS_OFS_STATUS, 32'h1, 2'h0);
    aits_field_i.start();
    aits_field_i.set_ua(15'h4E20);
    wt(40);
    chk("low_trip", low_trip, 32'h0);
    aits_field_i.stop();
  endtask
  task automatic t_high();
    wr(`AITS_OFS_HIGH_GRACE, 32'h3FF, 2'h0);
    wr(`AITS_OFS_HIGH_DELAY, 32'h1, 2'h0);
    wt(40);
    chk("high_trip", high_trip, 32'h0);
    wr(`AITS_OFS_HIGH_LEVEL, 32'h3E8, 2'h0);
    wt(30);
    chk("high_trip", high_trip, 32'h0);
    wr(`AITS_OFS_HIGH_DELAY, 32'h2, 2'h0);
    wr(`AITS_OFS_HIGH_LEVEL, 32'h258, 2'h0);
    wt(8);
    chk("high_trip", high_trip, 32'h0);
    wt(30);
    chk("high_trip", high_trip, 32'h1);
    wr(`AITS_OFS_HIGH_DELAY, 32'h258, 2'h0);
    wr(`AITS_OFS_HIGH_GRACE, 32'h1, 2'h0);
    wr(`AITS_OFS_STATUS, 32'h2, 2'h0);
    aits_field_i.start();
    wt(30);
    chk("high_trip", high_trip, 32'h1);
    // high trip and high excursion set, low side healthy, windows closed
    rd(`AITS_OFS_STATUS, 32'hA);
  endtask
  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    aresetn = 1'b0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_scale();
    t_low_delay();
    t_low_start();
    t_high();
    summarize();
  end
  // the run needs some 500 cycles, so 10000 means a hang
  initial begin
    #200000;
    err_total++;
    summarize();
  end
endmodule
